// ==== design/lsp_pkg.sv ====
// constants for the length decoded serial load port
// Overview of operation
// - msb first, sample data on clock rise
// - eight bit frame loads configuration byte
// - sixteen bit frame loads reference first buffer
// - twenty-four bit frame loads loop divider
// - targets hold until select ends frame
// - low thirteen reference bits double buffered
// - top three reference bits act immediately
// - loop load also copies reference buffer
// - clockless select pulse copies reference buffer
// - no address bits, length picks target
// - registers writable in any order
// - select rising edge transfers shifted bits
// - select high ignores clocks, port idle
// - serial out on falling edges, default
`default_nettype none

package lsp_pkg;
    // **********************************************
    // frame lengths and field layout
    // **********************************************
    localparam int SHIFT_W = 24;
    localparam int CNT_W = 6;
    localparam logic [5:0] LEN_NONE = 6'h00;
    localparam logic [5:0] LEN_CFG = 6'h08;
    localparam logic [5:0] LEN_REF = 6'h10;
    localparam logic [5:0] LEN_LOOP = 6'h18;
    localparam int CFG_W = 8;
    localparam int REF_LOW_W = 13;
    localparam int REF_HIGH_W = 3;
    localparam int REF_HIGH_LSB = 13;
    localparam int AUX_MODE_LSB = 22;
    localparam int CFG_PORT_BIT = 1;
    // **********************************************
    // auxiliary output modes
    // **********************************************
    localparam logic [1:0] AUX_PORT = 2'h0;
    localparam logic [1:0] AUX_DATA_OUT = 2'h1;
    // **********************************************
    // values after reset
    // **********************************************
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [12:0] REF_LOW_RESET = 13'h0000;
    localparam logic [2:0] REF_HIGH_RESET = 3'h0;
    // data out mode selected so cascaded parts pass bits on
    localparam logic [23:0] LOOP_RESET = 24'h400000;
endpackage

`default_nettype wire

// ==== design/lsp_shifter.sv ====
// serial shift register with saturating bit counter
`default_nettype none

module lsp_shifter #(
    parameter int WIDTH = 24,
    parameter int CNT_W = 6
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // control
    input wire logic clear_in,
    input wire logic shift_in,
    input wire logic bit_in,
    // state
    output logic [WIDTH-1:0] data_out,
    output logic [CNT_W-1:0] count_out
);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    // shift keeps running past the width: only the last bits count
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            data_out <= '0;
        end else if (shift_in) begin
            data_out <= {data_out[WIDTH-2:0], bit_in};
        end
    end

    // counter saturates so long frames never alias short ones
    always_ff @(posedge clock_in) begin
        if (reset_in || clear_in) begin
            count_out <= '0;
        end else if (shift_in && count_out != CNT_MAX) begin
            count_out <= count_out + 1'b1;
        end
    end
endmodule // lsp_shifter

`default_nettype wire

// ==== design/lsp_sync.sv ====
// two flip-flop synchroniser for one pin level
`default_nettype none

module lsp_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // pin and its synchronised level
    input wire logic pin_in,
    output logic level_out
);
    logic meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            meta_r <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            meta_r <= pin_in;
            level_out <= meta_r;
        end
    end
endmodule // lsp_sync

`default_nettype wire

// ==== design/lsp_top.sv ====
// length decoded serial load port of the synthesizer
`default_nettype none

module lsp_top (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // serial pins from the host
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic port_select_n_in,
    // loaded words
    output logic [7:0] config_byte_out,
    output logic [2:0] ref_mode_out,
    output logic [12:0] ref_counter_out,
    output logic [23:0] loop_divider_out,
    output logic counters_reload_out,
    // auxiliary output
    output logic aux_out
);

    // **********************************************
    // pin synchronisers
    // **********************************************

    logic sck_s;
    logic din_s;
    logic sel_n_s;

    lsp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_sck (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .pin_in(serial_clock_in),
        .level_out(sck_s)
    );

    lsp_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_din (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .pin_in(serial_data_in),
        .level_out(din_s)
    );

    // select idles high, so it resets high
    lsp_sync #(
        .RESET_VAL(1'b1)
    ) u_sync_sel (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .pin_in(port_select_n_in),
        .level_out(sel_n_s)
    );

    // **********************************************
    // edge detection
    // **********************************************

    logic sck_d_r;
    logic sel_n_d_r;

    // previous levels, read only after synchronisation
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sck_d_r <= 1'b0;
            sel_n_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            sel_n_d_r <= sel_n_s;
        end
    end

    wire sel_low = ~sel_n_s;
    wire sck_rise = sck_s & ~sck_d_r & sel_low;
    wire sck_fall = ~sck_s & sck_d_r & sel_low;
    wire frame_end = sel_n_s & ~sel_n_d_r;

    // **********************************************
    // shift register and bit counter
    // **********************************************

    logic [23:0] shift_data;
    logic [5:0] bit_count;

    // data was synchronised alongside the clock, so the
    // sample taken with the rise still meets hold
    lsp_shifter #(
        .WIDTH(lsp_pkg::SHIFT_W),
        .CNT_W(lsp_pkg::CNT_W)
    ) u_shifter (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .clear_in(sel_n_s),
        .shift_in(sck_rise),
        .bit_in(din_s),
        .data_out(shift_data),
        .count_out(bit_count)
    );

    // **********************************************
    // length decode
    // **********************************************

    // the count alone picks the target, no address bits
    wire len_cfg = bit_count == lsp_pkg::LEN_CFG;
    wire len_ref = bit_count == lsp_pkg::LEN_REF;
    wire len_loop = bit_count == lsp_pkg::LEN_LOOP;
    wire len_none = bit_count == lsp_pkg::LEN_NONE;

    // each target decodes on its own, any order works
    wire load_cfg = frame_end & len_cfg;
    wire load_ref = frame_end & len_ref;
    wire load_loop = frame_end & len_loop;
    wire copy_ref = frame_end & (len_loop | len_none);

    // **********************************************
    // target registers
    // **********************************************

    logic [12:0] ref_first_r;

    // configuration byte, written only at frame end
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            config_byte_out <= lsp_pkg::CFG_RESET;
        end else if (load_cfg) begin
            config_byte_out <= shift_data[7:0];
        end
    end

    // first buffer plus the unbuffered mode bits
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ref_first_r <= lsp_pkg::REF_LOW_RESET;
            ref_mode_out <= lsp_pkg::REF_HIGH_RESET;
        end else if (load_ref) begin
            ref_first_r <= shift_data[12:0];
            ref_mode_out <= shift_data[15:13];
        end
    end

    // second buffer feeds the reference counter
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ref_counter_out <= lsp_pkg::REF_LOW_RESET;
        end else if (copy_ref) begin
            ref_counter_out <= ref_first_r;
        end
    end

    // loop divider word
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            loop_divider_out <= lsp_pkg::LOOP_RESET;
        end else if (load_loop) begin
            loop_divider_out <= shift_data;
        end
    end

    // one pulse tells the counters that new ratios stand
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            counters_reload_out <= 1'b0;
        end else begin
            counters_reload_out <= copy_ref;
        end
    end

    // **********************************************
    // auxiliary output
    // **********************************************

    wire [1:0] aux_mode = loop_divider_out[23:22];
    wire aux_data_mode = aux_mode == lsp_pkg::AUX_DATA_OUT;
    wire aux_port_mode = aux_mode == lsp_pkg::AUX_PORT;
    wire port_bit = config_byte_out[lsp_pkg::CFG_PORT_BIT];

    // divider monitor modes are not modelled here and read low
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            aux_out <= 1'b0;
        end else if (aux_data_mode) begin
            if (sck_fall) begin
                aux_out <= shift_data[23];
            end
        end else if (aux_port_mode) begin
            aux_out <= port_bit;
        end else begin
            aux_out <= 1'b0;
        end
    end

    // **********************************************
    // assertions
    // **********************************************

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    sequence s_end_cfg;
        frame_end && bit_count == 6'h08;
    endsequence

    sequence s_end_ref;
        frame_end && bit_count == 6'h10;
    endsequence

    sequence s_end_loop;
        frame_end && bit_count == 6'h18;
    endsequence

    sequence s_end_bare;
        frame_end && bit_count == 6'h00;
    endsequence

    property p_msb_first;
        sck_rise |=> shift_data[0] == $past(din_s)
            && shift_data[23:1] == $past(shift_data[22:0]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("shift did not take msb first");

    property p_cfg_load;
        s_end_cfg |=> config_byte_out == $past(shift_data[7:0]);
    endproperty
    a_cfg_load: assert property (p_cfg_load)
        else $error("eight bit frame not loaded");

    property p_ref_load;
        s_end_ref |=> ref_first_r == $past(shift_data[12:0])
            && ref_mode_out == $past(shift_data[15:13])
            && $stable(ref_counter_out);
    endproperty
    a_ref_load: assert property (p_ref_load)
        else $error("sixteen bit frame loaded wrongly");

    property p_loop_load;
        s_end_loop |=> loop_divider_out == $past(shift_data)
            && ref_counter_out == $past(ref_first_r)
            && counters_reload_out;
    endproperty
    a_loop_load: assert property (p_loop_load)
        else $error("loop frame did not update together");

    property p_hold;
        !frame_end |=> $stable(config_byte_out)
            && $stable(loop_divider_out) && $stable(ref_mode_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("target changed during shifting");

    property p_bare;
        s_end_bare |=> ref_counter_out == $past(ref_first_r)
            && $stable(loop_divider_out) && $stable(config_byte_out);
    endproperty
    a_bare: assert property (p_bare)
        else $error("bare select pulse misbehaved");

    property p_bad_len;
        frame_end && !len_cfg && !len_ref && !len_loop && !len_none
            |=> $stable(config_byte_out) && $stable(loop_divider_out)
            && $stable(ref_counter_out) && !counters_reload_out;
    endproperty
    a_bad_len: assert property (p_bad_len)
        else $error("odd length frame loaded a register");

    property p_idle;
        sel_n_s [*2] |-> bit_count == 6'h00;
    endproperty
    a_idle: assert property (p_idle)
        else $error("port not idle while select high");

    property p_count;
        sck_rise && bit_count != 6'h3F
            |=> bit_count == $past(bit_count) + 6'h01;
    endproperty
    a_count: assert property (p_count)
        else $error("rising edge not counted");

    property p_data_out;
        sck_fall && aux_data_mode
            |=> aux_out == $past(shift_data[23]);
    endproperty
    a_data_out: assert property (p_data_out)
        else $error("serial out not shifted on fall");

    // the counter buffer may only move on a copy strobe
    property p_ref_hold;
        !copy_ref |=> $stable(ref_counter_out);
    endproperty
    a_ref_hold: assert property (p_ref_hold)
        else $error("second reference buffer moved alone");

    // clock edges with select high must not disturb the shifter
    property p_sel_high;
        sel_n_s |=> $stable(shift_data);
    endproperty
    a_sel_high: assert property (p_sel_high)
        else $error("shift register moved while select high");

endmodule // lsp_top

`default_nettype wire

// ==== design/lsp_top_unused_placeholder.sv ====
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// ==== testbench/lsp_host_model.sv ====
// host model that drives the serial load pins of the port
`default_nettype none

module lsp_host_model (
    // clock
    input wire logic clock_in,
    // serial pins
    output logic serial_clock_out,
    output logic serial_data_out,
    output logic port_select_n_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // link clock rests low and select idles high outside frames
    initial begin
        serial_clock_out = 1'b0;
        serial_data_out = 1'b1;
        port_select_n_out = 1'b1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // one frame, msb first, 400 ns per bit; n of 0 is a bare select pulse
    // odd lengths are sent only when a test asks for them
    task automatic send(input int n, input logic [31:0] word);
        wait_cyc(1);
        port_select_n_out <= 1'b0;
        wait_cyc(4);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_out <= word[i];
            wait_cyc(2);
            serial_clock_out <= 1'b1;
            wait_cyc(4);
            serial_clock_out <= 1'b0;
            wait_cyc(2);
        end
        // select moves only with the clock low, 300 ns clear of its edge
        wait_cyc(4);
        port_select_n_out <= 1'b1;
        serial_data_out <= ~serial_data_out; // no stale bit left on the line
        wait_cyc(8);
    endtask

    // clock edges while select stays high
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            wait_cyc(4);
            serial_clock_out <= 1'b1;
            wait_cyc(4);
            serial_clock_out <= 1'b0;
        end
        wait_cyc(4);
    endtask
endmodule // lsp_host_model

`default_nettype wire

// ==== testbench/lsp_top_test.sv ====
// self-checking testbench of the length decoded serial load port
`default_nettype none

module lsp_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic sclk;
    logic sdat;
    logic sel_n;
    logic [7:0] config_byte;
    logic [2:0] ref_mode;
    logic [12:0] ref_counter;
    logic [23:0] loop_divider;
    logic reload;
    logic aux;
    int n_errors = 0;
    int check_count = 0;
    int reload_count = 0;
    int reload_exp = 0;

    // 20 MHz system clock
    always #25 clock_in = ~clock_in;

    lsp_top u_dut (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .serial_clock_in(sclk),
        .serial_data_in(sdat),
        .port_select_n_in(sel_n),
        .config_byte_out(config_byte),
        .ref_mode_out(ref_mode),
        .ref_counter_out(ref_counter),
        .loop_divider_out(loop_divider),
        .counters_reload_out(reload),
        .aux_out(aux)
    );

    lsp_host_model u_host (
        .clock_in(clock_in),
        .serial_clock_out(sclk),
        .serial_data_out(sdat),
        .port_select_n_out(sel_n)
    );

    // count one-cycle reload pulses so a missed or extra one shows
    always @(posedge clock_in) begin
        if (reload === 1'b1) begin
            reload_count++;
        end
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // let the edge's updates land before looking
    task automatic check_regs(input logic [7:0] c, input logic [2:0] m,
                              input logic [12:0] r, input logic [23:0] l);
        #1;
        check(24'(config_byte), 24'(c));
        check(24'(ref_mode), 24'(m));
        check(24'(ref_counter), 24'(r));
        check(loop_divider, l);
        check(24'(reload_count), 24'(reload_exp));
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // data out is the default mode; first bit reaches aux after 24 clocks
    task automatic test_data_out();
        fork
            u_host.send(24, 32'h00800000);
            begin
                repeat (100) @(posedge clock_in);
                check_regs(8'h00, 3'h0, 13'h0000, 24'h400000);
                check(24'(aux), 24'h000000);
                repeat (100) @(posedge clock_in);
                #1;
                check(24'(aux), 24'h000001);
            end
        join
        reload_exp++;
        check_regs(8'h00, 3'h0, 13'h0000, 24'h800000);
        check(24'(aux), 24'h000000);
    endtask

    task automatic test_words();
        u_host.send(8, 32'h000000A5);
        check_regs(8'hA5, 3'h0, 13'h0000, 24'h800000);
        u_host.send(16, 32'h0000B234);
        check_regs(8'hA5, 3'h5, 13'h0000, 24'h800000);
        // every loop word keeps main count at or above swallow
        u_host.send(24, 32'h00001234);
        reload_exp++;
        check_regs(8'hA5, 3'h5, 13'h1234, 24'h001234);
        check(24'(aux), 24'h000000);
        u_host.send(8, 32'h00000002);
        check_regs(8'h02, 3'h5, 13'h1234, 24'h001234);
        check(24'(aux), 24'h000001);
    endtask

    // a select pulse with no clocks moves only the reference buffer
    task automatic test_pulse();
        u_host.send(16, 32'h00000ABC);
        check_regs(8'h02, 3'h0, 13'h1234, 24'h001234);
        u_host.send(0, 32'h00000000);
        reload_exp++;
        check_regs(8'h02, 3'h0, 13'h0ABC, 24'h001234);
    endtask

    // odd lengths load nothing; clocks with select high do not count
    task automatic test_refused();
        u_host.send(12, 32'h00000FFF);
        check_regs(8'h02, 3'h0, 13'h0ABC, 24'h001234);
        u_host.idle_clocks(3);
        u_host.send(8, 32'h0000003C);
        check_regs(8'h3C, 3'h0, 13'h0ABC, 24'h001234);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        check_regs(8'h00, 3'h0, 13'h0000, 24'h400000);
        check(24'(aux), 24'h000000);
        test_data_out();
        test_words();
        test_pulse();
        test_refused();
        wrap_up();
    end

    // about 1130 cycles expected; cut off at 20000
    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end
endmodule // lsp_top_test

`default_nettype wire
